/* File: apc_defines.svh */
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH

// Clock rate and settling times
`define APC_CLK_MHZ          100
`define APC_PLL_SETTLE_NS    6000
`define APC_REF_SETTLE_NS    2000
`define APC_PLL_SETTLE_CYC   ((`APC_PLL_SETTLE_NS * `APC_CLK_MHZ + 999) / 1000)
`define APC_REF_SETTLE_CYC   ((`APC_REF_SETTLE_NS * `APC_CLK_MHZ + 999) / 1000)

// Interrupt line of the low-supply alarm
`define APC_LOW_SUPPLY_IRQ   17
`define APC_IRQ_LINES        32

// Reset values of the control bits
`define APC_RST_FAST_RC_PD   1'h0
`define APC_RST_REF_PD       1'h0
`define APC_RST_PLL_EN       1'h0
`define APC_RST_XTAL_EN      1'h0
`define APC_RST_MON_OFF      1'h0
`define APC_RST_MON_THR      2'h0
`define APC_RST_CONV_SEL     2'h0

// Settle counter width
`define APC_CNT_W            10

`endif

/* File: apc_pkg.sv */
package apc_pkg;

  // Software controls of the analog support circuits
  typedef struct packed {
    logic       fast_rc_powerdown;
    logic       reference_powerdown;
    logic       multiplier_loop_enable;
    logic       crystal_osc_enable;
    logic       supply_monitor_off;
    logic [1:0] supply_monitor_threshold;
    logic [1:0] converter_clock_select;
  } apc_ctrl_t;

  // Readable status
  typedef struct packed {
    logic low_supply_flag;
    logic pll_ready;
    logic reference_ready;
  } apc_stat_t;

  typedef enum logic [1:0] {
    APC_OFF      = 2'b00,
    APC_SETTLING = 2'b01,
    APC_READY    = 2'b10
  } apc_settle_st_t;

endpackage

/* File: apc_settle.sv */
`timescale 1ns/100ps
`include "apc_defines.svh"

module apc_settle
  import apc_pkg::*;
#(
  parameter logic [`APC_CNT_W-1:0] CYCLES = 10'h001
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic enable,
  output logic      ready
);

  typedef struct packed {
    apc_settle_st_t        st;
    logic [`APC_CNT_W-1:0] cnt;
    logic                  rdy;
  } apc_settle_state_t;

  apc_settle_state_t st_r;
  apc_settle_state_t st_nxt;

  // Count settling time from enable, drop at once on disable
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.st)
      APC_OFF: begin
        st_nxt.cnt = '0;
        st_nxt.rdy = 1'b0;
        if (enable) begin
          st_nxt.st = APC_SETTLING;
        end
      end
      APC_SETTLING: begin
        if (!enable) begin
          st_nxt.st  = APC_OFF;
          st_nxt.cnt = '0;
        end else if (st_r.cnt == CYCLES - 10'h001) begin
          st_nxt.st  = APC_READY;  // see (R19)
          st_nxt.rdy = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 10'h001;
        end
      end
      APC_READY: begin
        if (!enable) begin
          st_nxt.st  = APC_OFF;
          st_nxt.rdy = 1'b0;
        end
      end
      default: begin
        st_nxt.st  = APC_OFF;
        st_nxt.cnt = '0;
        st_nxt.rdy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ready = st_r.rdy;

endmodule

/* File: apc_ctrl.sv */
// Function
// (R01) Hold digital reset while analog supply low
// (R02) Alarm when supply below selected threshold
// (R03) Monitor off suppresses low-supply alarm
// (R04) Alarm drives interrupt line seventeen
// (R05) Low-supply flag readable as status
// (R06) Fast RC powerdown zero runs oscillator
// (R07) Software enables reference before fast RC
// (R08) Fast RC and reference on after reset
// (R09) Loop enable one turns PLL on
// (R10) PLL unstable until six microseconds elapse
// (R11) Software enables reference before PLL
// (R12) PLL multiplies fast RC, up to 96MHz
// (R13) Converter clock from PLL, two-bit select
// (R14) Crystal enable one starts backup oscillator
// (R15) Reference on when zero, settles two microseconds
// (R16) Software enables reference before analog users
// (R17) Slow RC clocks watchdog and reset filters
// (R18) Fast RC selectable main clock, PLL reference
// (R19) Ready flags assert after settling counted
`timescale 1ns/100ps
`include "apc_defines.svh"

module apc_ctrl
  import apc_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire apc_ctrl_t                   ctrl_in,
  input  wire logic                        ctrl_we,
  input  wire logic                        por_supply_ok,
  input  wire logic                        monitor_low,
  input  wire logic                        main_clk_use_pll,
  output apc_ctrl_t                        ctrl_out,
  output logic                             fast_rc_powerdown,
  output logic                             reference_powerdown,
  output logic                             multiplier_loop_enable,
  output logic                             crystal_osc_enable,
  output logic                             supply_monitor_off,
  output logic [1:0]                       supply_monitor_threshold,
  output logic [1:0]                       converter_clock_select,
  output logic                             pll_ref_from_fast_rc,
  output logic                             main_clk_sel_pll,
  output logic                             slow_rc_to_watchdog,
  output logic                             digital_reset_n,
  output logic [`APC_IRQ_LINES-1:0]        irq_lines,
  output apc_stat_t                        status
);

  typedef struct packed {
    apc_ctrl_t                  ctrl;
    logic                       por_s1;
    logic                       por_s2;
    logic                       low_s1;
    logic                       low_s2;
    logic                       dig_rst_n;
    logic                       low_flag;
    logic [`APC_IRQ_LINES-1:0]  irq;
    logic                       main_pll;
    logic                       pll_rdy;
    logic                       ref_rdy;
  } apc_state_t;

  localparam logic [`APC_CNT_W-1:0] PLL_CYC =
    `APC_CNT_W'(`APC_PLL_SETTLE_CYC);
  localparam logic [`APC_CNT_W-1:0] REF_CYC =
    `APC_CNT_W'(`APC_REF_SETTLE_CYC);

  apc_state_t st_r;
  apc_state_t st_nxt;
  logic       pll_ready_w;
  logic       ref_ready_w;
  logic       pll_on;
  logic       ref_on;

  // Reset image of the controls
  function automatic apc_ctrl_t ctrl_reset();
    apc_ctrl_t c;
    c.fast_rc_powerdown        = `APC_RST_FAST_RC_PD;
    c.reference_powerdown      = `APC_RST_REF_PD;
    c.multiplier_loop_enable   = `APC_RST_PLL_EN;
    c.crystal_osc_enable       = `APC_RST_XTAL_EN;
    c.supply_monitor_off       = `APC_RST_MON_OFF;
    c.supply_monitor_threshold = `APC_RST_MON_THR;
    c.converter_clock_select   = `APC_RST_CONV_SEL;
    return c;
  endfunction

  // Settling trackers fed by the registered enables
  assign pll_on = st_r.ctrl.multiplier_loop_enable;  // see (R09)
  assign ref_on = !st_r.ctrl.reference_powerdown;    // see (R15)

  apc_settle #(
    .CYCLES (PLL_CYC)
  ) u_pll_settle (
    .clock  (clock),
    .rst_n  (rst_n),
    .enable (pll_on),
    .ready  (pll_ready_w)
  );

  apc_settle #(
    .CYCLES (REF_CYC)
  ) u_ref_settle (
    .clock  (clock),
    .rst_n  (rst_n),
    .enable (ref_on),
    .ready  (ref_ready_w)
  );

  // Next-state logic of controls, reset hold and alarm
  always_comb begin
    st_nxt        = st_r;
    st_nxt.por_s1 = por_supply_ok;
    st_nxt.por_s2 = st_r.por_s1;
    st_nxt.low_s1 = monitor_low;
    st_nxt.low_s2 = st_r.low_s1;
    if (ctrl_we) begin
      st_nxt.ctrl = ctrl_in;
    end
    // Digital logic held in reset while supply is low
    st_nxt.dig_rst_n = st_r.por_s2;  // see (R01)
    if (!st_r.por_s2) begin
      st_nxt.ctrl = ctrl_reset();  // see (R08)
    end
    // Alarm only while the monitor is on
    st_nxt.low_flag = st_r.low_s2 &&
                      !st_r.ctrl.supply_monitor_off;  // see (R02) (R03)
    st_nxt.irq = '0;
    st_nxt.irq[`APC_LOW_SUPPLY_IRQ] = st_nxt.low_flag;  // see (R04)
    // PLL may drive the main clock only once settled
    st_nxt.main_pll = main_clk_use_pll && pll_ready_w;  // see (R10) (R18)
    st_nxt.pll_rdy  = pll_ready_w;  // see (R19)
    st_nxt.ref_rdy  = ref_ready_w;  // see (R19)
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.ctrl <= ctrl_reset();  // see (R08)
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign ctrl_out                 = st_r.ctrl;
  assign fast_rc_powerdown        = st_r.ctrl.fast_rc_powerdown;  // see (R06)
  assign reference_powerdown      =
    st_r.ctrl.reference_powerdown;  // see (R15)
  assign multiplier_loop_enable   =
    st_r.ctrl.multiplier_loop_enable;  // see (R09) (R12)
  assign crystal_osc_enable       = st_r.ctrl.crystal_osc_enable;  // see (R14)
  assign supply_monitor_off       = st_r.ctrl.supply_monitor_off;  // see (R03)
  assign supply_monitor_threshold =
    st_r.ctrl.supply_monitor_threshold;  // see (R02)
  assign converter_clock_select   =
    st_r.ctrl.converter_clock_select;  // see (R13)
  assign pll_ref_from_fast_rc     = st_r.dig_rst_n;  // see (R18)
  assign main_clk_sel_pll         = st_r.main_pll;
  assign slow_rc_to_watchdog      = st_r.dig_rst_n;  // see (R17)
  assign digital_reset_n          = st_r.dig_rst_n;
  assign irq_lines                = st_r.irq;
  assign status.low_supply_flag   = st_r.low_flag;  // see (R05)
  assign status.pll_ready         = st_r.pll_rdy;
  assign status.reference_ready   = st_r.ref_rdy;

endmodule

/* File: apc_ctrl_sva.sv */
`timescale 1ns/100ps
`include "apc_defines.svh"
module apc_ctrl_sva
  import apc_pkg::*;
(
  input wire logic                      clock,
  input wire logic                      rst_n,
  input wire apc_ctrl_t                 ctrl_in,
  input wire logic                      ctrl_we,
  input wire logic                      por_supply_ok,
  input wire logic                      monitor_low,
  input wire apc_ctrl_t                 ctrl_out,
  input wire logic                      multiplier_loop_enable,
  input wire logic                      reference_powerdown,
  input wire logic                      supply_monitor_off,
  input wire logic                      pll_ref_from_fast_rc,
  input wire logic                      main_clk_sel_pll,
  input wire logic                      slow_rc_to_watchdog,
  input wire logic                      digital_reset_n,
  input wire logic [`APC_IRQ_LINES-1:0] irq_lines,
  input wire apc_stat_t                 status
);
  logic [9:0] pll_cnt_r;
  logic [9:0] ref_cnt_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Cycles each circuit has been enabled, saturating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pll_cnt_r <= 10'h000;
      ref_cnt_r <= 10'h000;
    end else begin
      pll_cnt_r <= !multiplier_loop_enable ? 10'h000 :
                   pll_cnt_r + 10'(pll_cnt_r != 10'h3FF);
      ref_cnt_r <= reference_powerdown ? 10'h000 :
                   ref_cnt_r + 10'(ref_cnt_r != 10'h3FF);
    end
  end
  a_irq_only_17: assert property (irq_lines == {14'h0,
    status.low_supply_flag, 17'h0}) else $error("irq lines wrong");
  a_mon_off_clear: assert property (supply_monitor_off |=>
    !status.low_supply_flag) else $error("alarm while monitor off");
  a_alarm_raise: assert property ((monitor_low &&
    !supply_monitor_off)[*4] |-> status.low_supply_flag)
    else $error("alarm missing");
  a_pll_settle: assert property ($rose(status.pll_ready) |->
    pll_cnt_r >= 10'h258) else $error("pll ready too early");
  a_ref_settle: assert property ($rose(status.reference_ready)
    |-> ref_cnt_r >= 10'h0C8) else $error("reference ready too early");
  a_main_clk_gate: assert property (main_clk_sel_pll |->
    status.pll_ready) else $error("main clock on unsettled pll");
  a_slow_rc_follow: assert property (slow_rc_to_watchdog ==
    digital_reset_n && pll_ref_from_fast_rc == digital_reset_n)
    else $error("clock routing wrong");
  a_por_hold: assert property (!por_supply_ok |-> ##3
    (!digital_reset_n && ctrl_out == '0)) else $error("por not held");
  a_write_apply: assert property (ctrl_we && por_supply_ok &&
    digital_reset_n |=> ctrl_out == $past(ctrl_in)) else $error("write lost");
  // Main scenarios reached
  c_pll_ready: cover property ($rose(status.pll_ready));
  c_alarm: cover property ($rose(status.low_supply_flag));
  c_por_drop: cover property ($fell(digital_reset_n));
endmodule
bind apc_ctrl apc_ctrl_sva u_sva (.clock, .rst_n, .ctrl_in, .ctrl_we,
  .por_supply_ok, .monitor_low, .ctrl_out, .multiplier_loop_enable,
  .reference_powerdown, .supply_monitor_off, .pll_ref_from_fast_rc,
  .main_clk_sel_pll, .slow_rc_to_watchdog, .digital_reset_n, .irq_lines,
  .status);

/* File: apc_analog_model.sv */
`timescale 1ns/100ps
module apc_analog_model (
  input  wire logic [12:0] avdd_mv,
  input  wire logic [12:0] main_mv,
  input  wire logic [1:0]  supply_monitor_threshold,
  input  wire logic        supply_monitor_off,
  output logic             por_supply_ok,
  output logic             monitor_low
);
  logic [12:0] thr_mv;
  // Threshold steps down by 200 mV per select code from 4400 mV
  assign thr_mv = 13'h1130 - 13'h00C8 * 13'(supply_monitor_threshold);
  // Trip comparators of the supply detectors
  assign por_supply_ok = avdd_mv >= 13'h0BB8;
  assign monitor_low = !supply_monitor_off && main_mv < thr_mv;
endmodule

/* File: test_analog_power_clock_enable_ctrl.sv */
`timescale 1ns/100ps
`include "apc_defines.svh"
module test_analog_power_clock_enable_ctrl
  import apc_pkg::*;
;
  logic                      clock, rst_n, ctrl_we, main_clk_use_pll;
  logic                      por_supply_ok, monitor_low;
  logic                      main_clk_sel_pll, digital_reset_n;
  logic [12:0]               avdd_mv, main_mv;
  logic [31:0]               seed;
  logic [`APC_IRQ_LINES-1:0] irq_lines;
  logic [23:0]               exp_q[$];
  apc_ctrl_t                 ctrl_in, ctrl_out, exp_c, v;
  wire apc_ctrl_t            fld;
  apc_stat_t                 status;
  int                        miscompares, checks_done, cycles;
  event                      chk_ev;
  apc_ctrl dut (.clock, .rst_n, .ctrl_in, .ctrl_we, .por_supply_ok,
    .monitor_low, .main_clk_use_pll, .ctrl_out,
    .fast_rc_powerdown(fld.fast_rc_powerdown),
    .reference_powerdown(fld.reference_powerdown),
    .multiplier_loop_enable(fld.multiplier_loop_enable),
    .crystal_osc_enable(fld.crystal_osc_enable),
    .supply_monitor_off(fld.supply_monitor_off),
    .supply_monitor_threshold(fld.supply_monitor_threshold),
    .converter_clock_select(fld.converter_clock_select),
    .pll_ref_from_fast_rc(), .main_clk_sel_pll, .slow_rc_to_watchdog(),
    .digital_reset_n, .irq_lines, .status);
  apc_analog_model u_ana (.avdd_mv, .main_mv, .por_supply_ok, .monitor_low,
    .supply_monitor_threshold(fld.supply_monitor_threshold),
    .supply_monitor_off(fld.supply_monitor_off));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Note the expected snapshot of controls, status, reset, IRQ line 17 and PLL select
  task automatic expect_out(input logic [2:0] st, input logic dr, fl, sel);
    @(negedge clock);
    exp_q.push_back({exp_c, exp_c, st, dr, fl, sel});
    -> chk_ev;
  endtask
  task automatic write(input apc_ctrl_t val);
    @(negedge clock);
    ctrl_in = val;
    ctrl_we = 1'b1;
    @(negedge clock);
    ctrl_we = 1'b0;
    exp_c = val;
  endtask
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  // Compare each snapshot with the oldest note
  initial forever begin
    @(chk_ev);
    checks_done++;
    if ({ctrl_out, fld, status, digital_reset_n, irq_lines[17],
         main_clk_sel_pll} !== exp_q[0]) begin
      miscompares++;
      $display("[FAIL] outputs exp %h got %h", exp_q[0], {ctrl_out, fld,
               status, digital_reset_n, irq_lines[17], main_clk_sel_pll});
    end
    void'(exp_q.pop_front());
  end
  initial begin
    {rst_n, ctrl_we, main_clk_use_pll, ctrl_in, exp_c} = '0;
    {miscompares, checks_done, cycles} = '0;
    avdd_mv = 13'h0800;
    main_mv = 13'h1388;
    seed = 32'h00014D69;
    repeat (6) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    expect_out(3'b000, 1'b0, 1'b0, 1'b0);
    avdd_mv = 13'h0CE4;
    repeat (4) @(negedge clock);
    expect_out(3'b000, 1'b1, 1'b0, 1'b0);
    repeat (220) @(negedge clock);
    expect_out(3'b001, 1'b1, 1'b0, 1'b0);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      v = apc_ctrl_t'(seed[8:0]);
      {v.reference_powerdown, v.multiplier_loop_enable} = 2'h0;
      write(v);
      expect_out(3'b001, 1'b1, 1'b0, 1'b0);
    end
    v = '0;
    v.multiplier_loop_enable = 1'b1;
    main_clk_use_pll = 1'b1;
    write(v);
    repeat (300) @(negedge clock);
    expect_out(3'b001, 1'b1, 1'b0, 1'b0);
    repeat (320) @(negedge clock);
    expect_out(3'b011, 1'b1, 1'b0, 1'b1);
    write('0);
    repeat (3) @(negedge clock);
    expect_out(3'b001, 1'b1, 1'b0, 1'b0);
    $display("test pll done");
    for (int t = 0; t < 4; t++) begin
      v = '0;
      v.supply_monitor_threshold = 2'(t);
      write(v);
      main_mv = 13'h10CC - 13'h00C8 * 13'(t);
      repeat (5) @(negedge clock);
      expect_out(3'b101, 1'b1, 1'b1, 1'b0);
      v.supply_monitor_off = 1'b1;
      write(v);
      repeat (3) @(negedge clock);
      expect_out(3'b001, 1'b1, 1'b0, 1'b0);
    end
    main_mv = 13'h1388;
    $display("test alarm done");
    v.crystal_osc_enable = 1'b1;
    write(v);
    avdd_mv = 13'h0800;
    repeat (5) @(negedge clock);
    write(v);
    exp_c = '0;
    expect_out(3'b001, 1'b0, 1'b0, 1'b0);
    avdd_mv = 13'h0CE4;
    repeat (5) @(negedge clock);
    expect_out(3'b001, 1'b1, 1'b0, 1'b0);
    $display("test por done");
    @(negedge clock);
    complete_run();
  end
endmodule
